// ==== core/capture_compare_unit.sv ====
// Function
// - capture copies full timer count into value
// - mode picks falling, rising, 4th, 16th edge
// - capture sets unit flag; software clears it
// - new capture overwrites unread value
// - driven port latch change can capture
// - prescaler cleared when off or not capturing
// - capture setting switch keeps prescaler count
// - compare match sets flag; only toggle, set, clear modes act on pin
// - entering set/clear compare presets output latch
// - zero control write off, latch low
// - software compare mode only sets flag
// - special trigger match resets timer pair
// - special trigger starts conversion if enabled
// - trigger reset leaves overflow flag untouched
`timescale 1ns/1ns
module capture_compare_unit (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cc_pkg::ADDR_W-1:0] paddr,
  input wire logic [cc_pkg::DATA_W-1:0] pwdata,
  output logic [cc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer one
  input wire logic [cc_pkg::TIMER_W-1:0] timer_one_count,
  output logic timer_one_reset,
  // converter
  input wire logic adc_enabled,
  output logic adc_start,
  // capture compare pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // interrupt
  output logic irq
);

  // ****************************************
  // state
  // ****************************************
  logic [cc_pkg::CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [cc_pkg::TIMER_W-1:0] value_reg, value_next;
  logic flag_reg, flag_next;
  logic enable_reg, enable_next;
  logic dir_reg, dir_next;
  logic latch_reg, latch_next;
  logic out_latch_reg, out_latch_next;
  logic match_q_reg, match_q_next;
  logic tmr_rst_reg, tmr_rst_next;
  logic adc_start_reg, adc_start_next;
  logic pin_out_reg, pin_out_next;
  logic [cc_pkg::DATA_W-1:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;

  logic [cc_pkg::MODE_W-1:0] mode;
  logic [cc_pkg::MODE_W-1:0] new_mode;
  logic capture_mode;
  logic compare_mode;
  logic setup;
  logic wr;
  logic mapped;
  logic pin_level;
  logic rise;
  logic fall;
  logic capture_event;
  logic match;
  logic match_evt;
  logic flag_clear;

  assign mode = ctrl_reg[cc_pkg::MODE_LSB +: cc_pkg::MODE_W];
  assign new_mode = pwdata[cc_pkg::MODE_LSB +: cc_pkg::MODE_W];
  assign capture_mode = cc_pkg::is_capture(mode);
  assign compare_mode = cc_pkg::is_compare(mode);

  // ****************************************
  // pin sampling and capture events
  // ****************************************
  // the pad is sampled whatever its direction, so a port latch write that moves a driven pin is seen
  pin_edge_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_async(pin_in),
    .level(pin_level),
    .rise(rise),
    .fall(fall)
  );

  capture_prescaler u_presc (
    .clk(clk),
    .sys_rst(sys_rst),
    .mode(mode),
    .rise(rise),
    .fall(fall),
    .capture_event(capture_event)
  );

  // ****************************************
  // bus decode
  // ****************************************
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;

  always_comb begin
    case (paddr)
      cc_pkg::CTRL_ADDR,
      cc_pkg::VALUE_LOW_ADDR,
      cc_pkg::VALUE_HIGH_ADDR,
      cc_pkg::FLAG_ADDR,
      cc_pkg::FLAG_CLEAR_ADDR,
      cc_pkg::ENABLE_ADDR,
      cc_pkg::PORT_ADDR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************
  // compare
  // ****************************************
  // edge of equality, so a timer that rests on the value does not re-fire every cycle
  assign match = compare_mode && (value_reg == timer_one_count);
  assign match_evt = match && !match_q_reg;
  assign flag_clear = wr && (paddr == cc_pkg::FLAG_CLEAR_ADDR) && pwdata[cc_pkg::UNIT_FLAG_BIT];

  // ****************************************
  // register file
  // ****************************************
  always_comb begin
    ctrl_next = ctrl_reg;
    value_next = value_reg;
    enable_next = enable_reg;
    dir_next = dir_reg;
    latch_next = latch_reg;
    if (wr && mapped) begin
      case (paddr)
        cc_pkg::CTRL_ADDR: ctrl_next = pwdata[cc_pkg::CTRL_W-1:0];
        cc_pkg::VALUE_LOW_ADDR: value_next[cc_pkg::BYTE_W-1:0] = pwdata[cc_pkg::BYTE_W-1:0];
        cc_pkg::VALUE_HIGH_ADDR: value_next[cc_pkg::TIMER_W-1:cc_pkg::BYTE_W] = pwdata[cc_pkg::BYTE_W-1:0];
        cc_pkg::ENABLE_ADDR: enable_next = pwdata[cc_pkg::UNIT_FLAG_BIT];
        cc_pkg::PORT_ADDR: begin
          latch_next = pwdata[cc_pkg::PORT_LATCH_BIT];
          dir_next = pwdata[cc_pkg::PORT_DIR_BIT];
        end
        default: ;
      endcase
    end
    // a capture in the same cycle as a software write wins, the fresh count matters more
    if (capture_event) begin
      value_next = timer_one_count;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= cc_pkg::CTRL_RESET;
      value_reg <= cc_pkg::VALUE_RESET;
      enable_reg <= 1'b0;
      dir_reg <= cc_pkg::PORT_DIR_RESET;
      latch_reg <= cc_pkg::PORT_LATCH_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      value_reg <= value_next;
      enable_reg <= enable_next;
      dir_reg <= dir_next;
      latch_reg <= latch_next;
    end
  end

  // ****************************************
  // interrupt flag
  // ****************************************
  always_comb begin
    // set beats a clear that lands in the same cycle
    flag_next = capture_event || match_evt || (flag_reg && !flag_clear);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ****************************************
  // compare output latch and pin drive
  // ****************************************
  always_comb begin
    out_latch_next = out_latch_reg;
    match_q_next = match;
    if (wr && (paddr == cc_pkg::CTRL_ADDR)) begin
      if (pwdata[cc_pkg::CTRL_W-1:0] == cc_pkg::CTRL_RESET) begin
        out_latch_next = 1'b0;
      end else if (new_mode != mode && new_mode == cc_pkg::MODE_CMP_SET) begin
        out_latch_next = 1'b1;
      end else if (new_mode != mode && new_mode == cc_pkg::MODE_CMP_CLEAR) begin
        out_latch_next = 1'b0;
      end
    end else if (match_evt) begin
      case (mode)
        cc_pkg::MODE_CMP_TOGGLE: out_latch_next = !out_latch_reg;
        cc_pkg::MODE_CMP_SET: out_latch_next = 1'b1;
        cc_pkg::MODE_CMP_CLEAR: out_latch_next = 1'b0;
        default: out_latch_next = out_latch_reg;
      endcase
    end
    // compare modes drive the output latch, every other mode the port data latch
    pin_out_next = compare_mode ? out_latch_next : latch_next;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_latch_reg <= 1'b0;
      match_q_reg <= 1'b0;
      pin_out_reg <= cc_pkg::PORT_LATCH_RESET;
    end else begin
      out_latch_reg <= out_latch_next;
      match_q_reg <= match_q_next;
      pin_out_reg <= pin_out_next;
    end
  end

  // ****************************************
  // special event trigger
  // ****************************************
  // both pulses last one cycle; the timer clears on the edge that ends the pulse
  always_comb begin
    // the trigger reaches only the timer count; the overflow flag has no path from here
    tmr_rst_next = match_evt && (mode == cc_pkg::MODE_CMP_SPECIAL);
    adc_start_next = match_evt && (mode == cc_pkg::MODE_CMP_SPECIAL) && adc_enabled;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_rst_reg <= 1'b0;
      adc_start_reg <= 1'b0;
    end else begin
      tmr_rst_reg <= tmr_rst_next;
      adc_start_reg <= adc_start_next;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup) begin
      prdata_next = '0;
      pslverr_next = !mapped;
      if (!pwrite) begin
        case (paddr)
          cc_pkg::CTRL_ADDR: prdata_next[cc_pkg::CTRL_W-1:0] = ctrl_reg;
          cc_pkg::VALUE_LOW_ADDR: prdata_next[cc_pkg::BYTE_W-1:0] = value_reg[cc_pkg::BYTE_W-1:0];
          cc_pkg::VALUE_HIGH_ADDR:
            prdata_next[cc_pkg::BYTE_W-1:0] = value_reg[cc_pkg::TIMER_W-1:cc_pkg::BYTE_W];
          cc_pkg::FLAG_ADDR: prdata_next[cc_pkg::UNIT_FLAG_BIT] = flag_reg;
          cc_pkg::ENABLE_ADDR: prdata_next[cc_pkg::UNIT_FLAG_BIT] = enable_reg;
          cc_pkg::PORT_ADDR: begin
            prdata_next[cc_pkg::PORT_LATCH_BIT] = latch_reg;
            prdata_next[cc_pkg::PORT_DIR_BIT] = dir_reg;
            prdata_next[cc_pkg::PORT_PIN_BIT] = pin_level;
          end
          default: prdata_next = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // one wait-free access phase: read data was prepared during setup
  assign pready = 1'b1;
  assign pslverr = psel && penable && pslverr_reg;
  assign prdata = prdata_reg;
  assign timer_one_reset = tmr_rst_reg;
  assign adc_start = adc_start_reg;
  // direction bit high means input; drive only when software made the pin an output
  assign pin_oe = !dir_reg;
  assign pin_out = pin_out_reg;
  assign irq = flag_reg && enable_reg;

endmodule // capture_compare_unit

// ==== core/capture_prescaler.sv ====
`timescale 1ns/1ns
module capture_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // mode and edges
  input wire logic [cc_pkg::MODE_W-1:0] mode,
  input wire logic rise,
  input wire logic fall,
  // capture request
  output logic capture_event
);

  // ****************************************
  // edge counter
  // ****************************************
  logic [cc_pkg::PRESC_W-1:0] count_reg, count_next;
  logic active;

  always_comb begin
    active = cc_pkg::is_capture(mode);
    count_next = count_reg;
    capture_event = 1'b0;
    if (!active) begin
      count_next = cc_pkg::PRESC_ZERO;
    end else begin
      // a switch between capture settings keeps the count running
      if (rise) begin
        count_next = count_reg + cc_pkg::PRESC_ONE;
      end
      case (mode)
        cc_pkg::MODE_CAP_FALL: capture_event = fall;
        cc_pkg::MODE_CAP_RISE: capture_event = rise;
        cc_pkg::MODE_CAP_RISE4: capture_event = rise && (count_reg[1:0] == cc_pkg::PRESC_LAST4[1:0]);
        cc_pkg::MODE_CAP_RISE16: capture_event = rise && (count_reg == cc_pkg::PRESC_LAST16);
        default: capture_event = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= cc_pkg::PRESC_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule // capture_prescaler

// ==== core/cc_pkg.sv ====
package cc_pkg;

  // ****************************************
  // bus and data widths
  // ****************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned TIMER_W = 16;
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned MODE_W = 4;
  localparam int unsigned PRESC_W = 4;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] VALUE_LOW_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] VALUE_HIGH_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] FLAG_ADDR = 8'h0c;
  localparam logic [ADDR_W-1:0] FLAG_CLEAR_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] ENABLE_ADDR = 8'h14;
  localparam logic [ADDR_W-1:0] PORT_ADDR = 8'h18;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned UNIT_FLAG_BIT = 2;
  localparam int unsigned PORT_LATCH_BIT = 0;
  localparam int unsigned PORT_DIR_BIT = 1;
  localparam int unsigned PORT_PIN_BIT = 2;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned BYTE_W = 8;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [TIMER_W-1:0] VALUE_RESET = 16'h0000;
  localparam logic PORT_DIR_RESET = 1'b1;
  localparam logic PORT_LATCH_RESET = 1'b0;

  // ****************************************
  // mode select codes
  // ****************************************
  localparam logic [MODE_W-1:0] MODE_OFF = 4'h0;
  localparam logic [MODE_W-1:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [MODE_W-1:0] MODE_CAP_FALL = 4'h4;
  localparam logic [MODE_W-1:0] MODE_CAP_RISE = 4'h5;
  localparam logic [MODE_W-1:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [MODE_W-1:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [MODE_W-1:0] MODE_CMP_SET = 4'h8;
  localparam logic [MODE_W-1:0] MODE_CMP_CLEAR = 4'h9;
  localparam logic [MODE_W-1:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [MODE_W-1:0] MODE_CMP_SPECIAL = 4'hb;

  // ****************************************
  // prescaler terminal counts
  // ****************************************
  localparam logic [PRESC_W-1:0] PRESC_LAST4 = 4'h3;
  localparam logic [PRESC_W-1:0] PRESC_LAST16 = 4'hf;
  localparam logic [PRESC_W-1:0] PRESC_ZERO = 4'h0;
  localparam logic [PRESC_W-1:0] PRESC_ONE = 4'h1;

  // ****************************************
  // mode decoding
  // ****************************************
  function automatic logic is_capture(input logic [MODE_W-1:0] mode);
    is_capture = (mode == MODE_CAP_FALL) || (mode == MODE_CAP_RISE) ||
                 (mode == MODE_CAP_RISE4) || (mode == MODE_CAP_RISE16);
  endfunction

  function automatic logic is_compare(input logic [MODE_W-1:0] mode);
    is_compare = (mode == MODE_CMP_TOGGLE) || (mode == MODE_CMP_SET) || (mode == MODE_CMP_CLEAR) ||
                 (mode == MODE_CMP_SOFT) || (mode == MODE_CMP_SPECIAL);
  endfunction

endpackage

// ==== core/pin_edge_sync.sv ====
`timescale 1ns/1ns
module pin_edge_sync (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pin sample
  input wire logic pin_async,
  // edge pulses
  output logic level,
  output logic rise,
  output logic fall
);

  // ****************************************
  // two stage synchroniser and edge history
  // ****************************************
  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic prev_reg, prev_next;

  always_comb begin
    meta_next = pin_async;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  // edges come only from the settled stages, one pulse per transition
  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;

endmodule // pin_edge_sync

// ==== sim/cc_far_side.sv ====
`timescale 1ns/1ns
module cc_far_side (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // timer one
  input wire logic timer_run,
  input wire logic [cc_pkg::TIMER_W-1:0] timer_preset,
  input wire logic timer_one_reset,
  output logic [cc_pkg::TIMER_W-1:0] timer_one_count,
  // pin
  input wire logic ext_level,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_wire
);
  // ****
  // timer one, counting on the system clock
  // ****
  logic [cc_pkg::TIMER_W-1:0] count_reg;
  logic [cc_pkg::TIMER_W-1:0] count_next;
  always_comb begin
    count_next = timer_run ? count_reg + 16'h0001 : timer_preset;
    if (timer_one_reset) begin
      count_next = 16'h0000;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= 16'h0000;
    end else begin
      count_reg <= count_next;
    end
  end
  assign timer_one_count = count_reg;
  // source lets go of the pin while the unit drives it
  assign pin_wire = pin_oe ? pin_out : ext_level;
endmodule // cc_far_side

// ==== sim/cc_sva.sv ====
`timescale 1ns/1ns
module cc_sva (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cc_pkg::ADDR_W-1:0] paddr,
  input wire logic [cc_pkg::DATA_W-1:0] pwdata,
  input wire logic [cc_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // unit outputs and converter enable input
  input wire logic timer_one_reset,
  input wire logic adc_enabled,
  input wire logic adc_start,
  input wire logic pin_out,
  input wire logic pin_oe
);
  // ****
  // mode shadow
  // ****
  logic [cc_pkg::MODE_W-1:0] mode_reg;
  logic [cc_pkg::MODE_W-1:0] mode_next;
  logic acc;
  logic wr_ctrl;
  logic wr_port;
  logic bad_addr;
  assign acc = psel && penable;
  assign wr_ctrl = acc && pwrite && paddr == cc_pkg::CTRL_ADDR;
  assign wr_port = acc && pwrite && paddr == cc_pkg::PORT_ADDR;
  assign bad_addr = paddr[1:0] != 2'h0 || paddr > cc_pkg::PORT_ADDR;
  always_comb begin
    mode_next = wr_ctrl ? pwdata[3:0] : mode_reg;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= cc_pkg::MODE_OFF;
    end else begin
      mode_reg <= mode_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****
  // assertions
  // ****
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_phase: assert property (pslverr |-> acc) else $error("error outside access");
  a_err_map: assert property (acc && bad_addr |-> pslverr) else $error("unmapped without error");
  a_rd_zero: assert property (acc && !pwrite && bad_addr |-> prdata == '0) else $error("unmapped read data");
  a_oe_dir: assert property (wr_port |=> ##1 pin_oe == !$past(pwdata[cc_pkg::PORT_DIR_BIT], 2))
    else $error("pin enable not from direction");
  a_trig_pulse: assert property (timer_one_reset |=> !timer_one_reset) else $error("trigger too long");
  a_trig_mode: assert property (timer_one_reset |-> $past(mode_reg) == cc_pkg::MODE_CMP_SPECIAL)
    else $error("trigger outside special mode");
  a_adc_only: assert property (adc_start |-> timer_one_reset) else $error("conversion without trigger");
  a_adc_gate: assert property (timer_one_reset |-> adc_start == $past(adc_enabled))
    else $error("conversion gating wrong");
  a_preset_set: assert property (wr_ctrl && pwdata[3:0] == cc_pkg::MODE_CMP_SET &&
    mode_reg != cc_pkg::MODE_CMP_SET |=> ##1 pin_out) else $error("set mode preset");
  a_preset_clr: assert property (wr_ctrl && pwdata[3:0] == cc_pkg::MODE_CMP_CLEAR &&
    mode_reg != cc_pkg::MODE_CMP_CLEAR |=> ##1 !pin_out) else $error("clear mode preset");
  a_soft_hold: assert property ((mode_reg == cc_pkg::MODE_CMP_SOFT) [*4] |-> $stable(pin_out))
    else $error("soft mode moved pin");
endmodule // cc_sva
bind capture_compare_unit cc_sva u_sva (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_one_reset(timer_one_reset), .adc_enabled(adc_enabled), .adc_start(adc_start), .pin_out(pin_out),
  .pin_oe(pin_oe));

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, timer_one_reset, adc_start, pin_in, pin_out, pin_oe, irq;
  logic adc_enabled = 1'b0;
  logic timer_run = 1'b0;
  logic ext_level = 1'b0;
  logic [15:0] timer_preset = 16'h0000;
  logic [15:0] timer_one_count, exp_v;
  logic [7:0] lo;
  logic [3:0] cap_m [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
  int cap_n [4] = '{1, 1, 4, 16};
  logic [3:0] cmp_m [4] = '{4'h8, 4'h9, 4'h2, 4'ha};
  logic cmp_e [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int trig_cnt = 0;
  int adc_cnt = 0;
  int t0, a0;
  always #20 clk = ~clk;
  capture_compare_unit dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_one_count(timer_one_count), .timer_one_reset(timer_one_reset), .adc_enabled(adc_enabled),
    .adc_start(adc_start), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  cc_far_side far (.clk(clk), .sys_rst(sys_rst), .timer_run(timer_run), .timer_preset(timer_preset),
    .timer_one_reset(timer_one_reset), .timer_one_count(timer_one_count), .ext_level(ext_level),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_wire(pin_in));
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // the cycle ceiling cuts short a hang
  always @(posedge clk) begin
    cycles++;
    if (timer_one_reset === 1'b1) trig_cnt++;
    if (adc_start === 1'b1) adc_cnt++;
    if (cycles == 30000) begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the write settle so callers never sample outputs at the edge that updates them
    @(posedge clk);
  endtask
  // each pulse gives one rising and one falling edge, with a fresh timer value
  task automatic pulse(input int n);
    repeat (n) begin
      timer_preset <= timer_preset + 16'h0111;
      ext_level <= 1'b1;
      repeat (6) @(posedge clk);
      ext_level <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, cc_pkg::CTRL_ADDR, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, cc_pkg::PORT_ADDR, 32'h0);
    `CHK(rd, 32'h2)
    `CHK(pin_oe, 1'b0)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, cc_pkg::CTRL_ADDR, 32'h0);
      apb(1'b1, cc_pkg::FLAG_CLEAR_ADDR, 32'h4);
      timer_preset <= 16'h1000;
      apb(1'b1, cc_pkg::CTRL_ADDR, {28'h0, cap_m[i]});
      pulse(cap_n[i] - 1);
      apb(1'b0, cc_pkg::FLAG_ADDR, 32'h0);
      `CHK(rd[2], 1'b0)
      pulse(cap_n[i] + 1);
      exp_v = 16'h1000 + 16'(2 * cap_n[i]) * 16'h0111;
      apb(1'b0, cc_pkg::FLAG_ADDR, 32'h0);
      `CHK(rd[2], 1'b1)
      `CHK(irq, 1'b0)
      apb(1'b0, cc_pkg::VALUE_LOW_ADDR, 32'h0);
      lo = rd[7:0];
      apb(1'b0, cc_pkg::VALUE_HIGH_ADDR, 32'h0);
      `CHK({rd[7:0], lo}, exp_v)
    end
    apb(1'b1, cc_pkg::ENABLE_ADDR, 32'h4);
    `CHK(irq, 1'b1)
    apb(1'b1, cc_pkg::FLAG_CLEAR_ADDR, 32'h4);
    `CHK(irq, 1'b0)
    pulse(3);
    apb(1'b1, cc_pkg::CTRL_ADDR, 32'h0);
    apb(1'b1, cc_pkg::CTRL_ADDR, 32'h6);
    pulse(3);
    `CHK(irq, 1'b0)
    apb(1'b1, cc_pkg::PORT_ADDR, 32'h0);
    apb(1'b1, cc_pkg::CTRL_ADDR, 32'h5);
    apb(1'b1, cc_pkg::PORT_ADDR, 32'h1);
    repeat (8) @(posedge clk);
    `CHK(irq, 1'b1)
    $display("test capture done");
    apb(1'b1, cc_pkg::VALUE_LOW_ADDR, 32'h40);
    apb(1'b1, cc_pkg::VALUE_HIGH_ADDR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, cc_pkg::CTRL_ADDR, 32'h0);
      apb(1'b1, cc_pkg::FLAG_CLEAR_ADDR, 32'h4);
      timer_preset <= 16'h0000;
      apb(1'b1, cc_pkg::CTRL_ADDR, {28'h0, cmp_m[i]});
      repeat (3) @(posedge clk);
      `CHK(pin_out, cmp_m[i] == cc_pkg::MODE_CMP_SET)
      timer_run <= 1'b1;
      repeat (90) @(posedge clk);
      timer_run <= 1'b0;
      `CHK(irq, 1'b1)
      `CHK(pin_out, cmp_e[i])
    end
    apb(1'b0, cc_pkg::PORT_ADDR, 32'h0);
    `CHK(rd[0], 1'b1)
    $display("test compare done");
    apb(1'b1, cc_pkg::CTRL_ADDR, 32'h0);
    apb(1'b1, cc_pkg::CTRL_ADDR, 32'hb);
    adc_enabled <= 1'b1;
    t0 = trig_cnt;
    a0 = adc_cnt;
    timer_run <= 1'b1;
    repeat (180) @(posedge clk);
    `CHK(trig_cnt - t0 >= 2 && trig_cnt - t0 <= 3, 1'b1)
    `CHK(adc_cnt - a0 == trig_cnt - t0, 1'b1)
    adc_enabled <= 1'b0;
    t0 = trig_cnt;
    a0 = adc_cnt;
    repeat (180) @(posedge clk);
    `CHK(adc_cnt == a0 && trig_cnt - t0 >= 2, 1'b1)
    $display("test special trigger done");
    end_sim();
  end
endmodule // testbench
